// ### shared/nco_pkg.sv
package nco_pkg;
    // Datapath widths
    localparam int FREQ_W   = 48;
    localparam int SER_W    = 40;
    localparam int ADDR_W   = 24;
    localparam int AMP_W    = 16;
    localparam int DAC_W    = 14;
    localparam int NUM_MST  = 14;

    // Parallel register addresses
    localparam logic [3:0] CENTER_BASE = 4'h0;
    localparam logic [3:0] OFFSET_BASE = 4'h6;
    localparam logic [3:0] ADDR_SCFG   = 4'hc;
    localparam logic [3:0] ADDR_CTRL   = 4'hd;
    localparam logic [3:0] ADDR_XFER   = 4'hf;

    // Field positions
    localparam int CTRL_SER_OFF = 6;
    localparam int CTRL_CTR_OFF = 7;
    localparam int SCFG_LEN_LSB = 0;

    // Reset values: center word is a quarter of the clock rate
    localparam logic [47:0] CENTER_RST = 48'h4000_0000_0000;
    localparam logic [47:0] OFFSET_RST = 48'h0000_0000_0000;
    localparam logic [7:0]  SCFG_RST   = 8'h05;
    localparam logic [7:0]  CTRL_RST   = 8'h00;
    localparam logic [39:0] SERIAL_RST = 40'h00_0000_0000;
    localparam logic [8*NUM_MST-1:0] MST_RST = {CTRL_RST, SCFG_RST, OFFSET_RST, CENTER_RST};

    // Timing counts in core clock cycles; SER_TAIL in serial clocks, SER_MAX_N in bytes
    localparam int SYNC_STAGES  = 2;
    localparam int XFER_EXTRA   = 3;
    localparam int OFFSET_EXTRA = 4;
    localparam int SERIAL_EXTRA = 4;
    localparam int OUT_EXTRA    = 4;
    localparam int SER_TAIL     = 2;
    localparam int SER_MAX_N    = 5;
endpackage

// ### core/nco_frequency_control.sv
`timescale 1ns/10ps
// Behaviour
// RL1: Phase increment is center plus offset plus serial word, low 48 bits kept.
// RL2: Center and serial terms zeroed by control bits, offset term by its pin.
// RL3: 48-bit accumulator adds the increment every clock and wraps.
// RL4: Top 24 accumulator bits address a sine table giving 16-bit samples. The table here takes only the top TBL_BITS of them (10 by default).
// RL5: Sine sample rounded to 14 bits for the converter each clock.
// RL6: Accumulator bit 47 is the top table address bit; table holds one period.
// RL7: Serial word of 8 to 40 bits aligned at bit 47, lower bits zero.
// RL8: Write-only port: byte, 4-bit address, active-low enable, write strobe.
// RL9: Writes land in masters; transfer pin copies all masters to slaves.
// RL10: Strobe is asynchronous; writes accepted back to back at half clock rate.
// RL11: Output follows eleven clocks after write with transfer held, else fourteen.
// RL12: Host keeps transfer inactive until all bytes of a word are written.
// RL13: Center and offset registers have identical write and update latency.
// RL14: Offset enable pin gates offset term, effect visible fourteen clocks later.
// RL15: Finished serial word caught in holding register, then moved to slave.
// RL16: Host gives 8N+3 serial clocks per word, N from 1 to 5.
// RL17: Output reflects serial slave word twelve clocks after it is loaded.
// RL18: Two phase-select pins add 0, 90, 180 or 270 degrees.
// RL19: Any write to register 15 acts as a transfer.
// RL20: Phase, offset-enable and transfer pins pass two-flop synchronisers.
// RL21: Reset: center is quarter rate, offset off, serial enabled.
// RL22: Host waits one clock edge after reset release before writing.
// RL23: Phase code times 90 degrees added into top two phase bits.
// RL24: Each 48-bit word is six byte registers at their own addresses.
// RL25: Holding to slave move uses a request and acknowledge handshake.
module nco_frequency_control #(
    parameter int TBL_BITS = 10
) (
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic [7:0]  wr_data,
    input  wire logic [3:0]  wr_addr,
    input  wire logic        wr_enable_n,
    input  wire logic        wr_strobe,
    input  wire logic        update_n,
    input  wire logic        phase_select_low,
    input  wire logic        phase_select_high,
    input  wire logic        offset_word_enable,
    input  wire logic        ser_clk,
    input  wire logic        ser_data,
    input  wire logic        ser_sync,
    output logic [13:0]      dac_sample
);
    localparam int TBL_N = 2 ** TBL_BITS;

    generate
        if (TBL_BITS < 2 || TBL_BITS > nco_pkg::ADDR_W) begin : g_bad
            $error("TBL_BITS out of range");
        end
    endgenerate

    // Two-flop synchronisers for every pin
    localparam int NPIN = 20;
    logic [NPIN-1:0] pin_s1_q;
    logic [NPIN-1:0] pin_s2_q;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1_q <= '0;
            pin_s2_q <= '0;
        end else begin
            pin_s1_q <= {wr_data, wr_addr, ~wr_enable_n, wr_strobe, ~update_n,
                         phase_select_high, phase_select_low, offset_word_enable,
                         ser_clk, ser_data}; // RL20
            pin_s2_q <= pin_s1_q;
        end
    end
    // Enable pin inverted at the input so reset reads as not enabled
    logic [7:0] d_s;
    logic [3:0] a_s;
    logic       we_s;
    logic       wr_s;
    logic       upd_s;
    logic [1:0] ph_s;
    logic       ofs_s;
    logic       sck_s;
    logic       sda_s;
    assign {d_s, a_s, we_s, wr_s, upd_s, ph_s, ofs_s, sck_s, sda_s} = pin_s2_q;
    logic wr_prev_q;
    logic sck_prev_q;
    logic sync_s1_q;
    logic sync_s2_q;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_prev_q  <= 1'b0;
            sck_prev_q <= 1'b0;
            sync_s1_q  <= 1'b0;
            sync_s2_q  <= 1'b0;
        end else begin
            wr_prev_q  <= wr_s;
            sck_prev_q <= sck_s;
            sync_s1_q  <= ser_sync;
            sync_s2_q  <= sync_s1_q;
        end
    end
    logic wr_fire;
    assign wr_fire = wr_s && !wr_prev_q && we_s; // RL8 RL10

    // Master and slave byte registers
    logic [7:0] mst_q [nco_pkg::NUM_MST];
    logic [7:0] mst_d [nco_pkg::NUM_MST];
    logic [7:0] slv_q [nco_pkg::NUM_MST];
    logic [nco_pkg::XFER_EXTRA-1:0] xfer_dly_q;
    logic copy_en;
    assign copy_en = xfer_dly_q[nco_pkg::XFER_EXTRA-1]; // RL11
    genvar gi;
    for (gi = 0; gi < nco_pkg::NUM_MST; gi++) begin : g_reg
        always_comb begin
            mst_d[gi] = mst_q[gi];
            if (wr_fire && a_s == 4'(gi)) begin
                mst_d[gi] = d_s; // RL24 RL13
            end
        end
        always_ff @(posedge core_clk or negedge rst_n) begin
            if (!rst_n) begin
                mst_q[gi] <= nco_pkg::MST_RST[8*gi +: 8]; // RL21
                slv_q[gi] <= nco_pkg::MST_RST[8*gi +: 8];
            end else begin
                mst_q[gi] <= mst_d[gi]; // RL9
                if (copy_en) begin
                    slv_q[gi] <= mst_d[gi]; // RL9
                end
            end
        end
    end

    // Transfer request from pin or register 15, delayed to fourteen clocks
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            xfer_dly_q <= '0;
        end else begin
            xfer_dly_q <= {xfer_dly_q[nco_pkg::XFER_EXTRA-2:0],
                           upd_s || (wr_fire && a_s == nco_pkg::ADDR_XFER)}; // RL19
        end
    end

    // Offset enable delay
    logic [nco_pkg::OFFSET_EXTRA-1:0] ofs_dly_q;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ofs_dly_q <= '0;
        end else begin
            ofs_dly_q <= {ofs_dly_q[nco_pkg::OFFSET_EXTRA-2:0], ofs_s}; // RL14
        end
    end

    // Serial receiver on sampled shift clock edges
    logic [5:0]  ser_cnt_q;
    logic        ser_act_q;
    logic [39:0] ser_sh_q;
    logic [39:0] hold_q;
    logic        req_q;
    logic        ack_q;
    logic [2:0]  ser_n;
    logic [5:0]  ser_bits;
    logic        sck_rise;
    assign sck_rise = sck_s && !sck_prev_q;
    always_comb begin
        ser_n = slv_q[nco_pkg::ADDR_SCFG][nco_pkg::SCFG_LEN_LSB +: 3];
        if (ser_n == 3'h0 || ser_n > 3'(nco_pkg::SER_MAX_N)) begin
            ser_n = 3'(nco_pkg::SER_MAX_N);
        end
        ser_bits = {ser_n, 3'h0};
    end
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ser_cnt_q <= '0;
            ser_act_q <= 1'b0;
            ser_sh_q  <= '0;
            hold_q    <= nco_pkg::SERIAL_RST;
        end else if (sck_rise) begin
            if (sync_s2_q) begin
                ser_act_q <= 1'b1;
                ser_cnt_q <= '0;
                ser_sh_q  <= '0;
            end else if (ser_act_q) begin
                ser_cnt_q <= ser_cnt_q + 6'h01;
                if (ser_cnt_q < ser_bits) begin
                    ser_sh_q <= {ser_sh_q[38:0], sda_s};
                end
                if (ser_cnt_q == ser_bits + 6'(nco_pkg::SER_TAIL - 1)) begin
                    hold_q    <= ser_sh_q << (6'd40 - ser_bits); // RL15 RL7
                    ser_act_q <= 1'b0;
                end
            end
        end
    end
    logic hold_load;
    assign hold_load = sck_rise && !sync_s2_q && ser_act_q
                       && ser_cnt_q == ser_bits + 6'(nco_pkg::SER_TAIL - 1);

    // Holding to slave handshake; a new request wins over the clear
    logic [39:0] ser_slv_q;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            req_q     <= 1'b0;
            ack_q     <= 1'b0;
            ser_slv_q <= nco_pkg::SERIAL_RST;
        end else begin
            if (hold_load) begin
                req_q <= 1'b1; // RL25
            end else if (ack_q) begin
                req_q <= 1'b0;
            end
            ack_q <= req_q && !ack_q && !hold_load;
            if (req_q && !ack_q && !hold_load) begin
                ser_slv_q <= hold_q; // RL25 RL15
            end
        end
    end
    logic [39:0] ser_dly_q [nco_pkg::SERIAL_EXTRA];
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ser_dly_q <= '{default: '0};
        end else begin
            ser_dly_q[0] <= ser_slv_q; // RL17
            for (int k = 1; k < nco_pkg::SERIAL_EXTRA; k++) begin
                ser_dly_q[k] <= ser_dly_q[k-1];
            end
        end
    end

    // Term gating and sum
    logic [47:0] ctr_term;
    logic [47:0] ofs_term;
    logic [47:0] ser_term;
    always_comb begin
        ctr_term = {slv_q[5], slv_q[4], slv_q[3], slv_q[2], slv_q[1], slv_q[0]};
        ofs_term = {slv_q[11], slv_q[10], slv_q[9], slv_q[8], slv_q[7], slv_q[6]};
        ser_term = {ser_dly_q[nco_pkg::SERIAL_EXTRA-1], 8'h00}; // RL7
        if (slv_q[nco_pkg::ADDR_CTRL][nco_pkg::CTRL_CTR_OFF]) begin
            ctr_term = '0; // RL2
        end
        if (!ofs_dly_q[nco_pkg::OFFSET_EXTRA-1]) begin
            ofs_term = '0; // RL2 RL14
        end
        if (slv_q[nco_pkg::ADDR_CTRL][nco_pkg::CTRL_SER_OFF]) begin
            ser_term = '0; // RL2
        end
    end
    logic [47:0] freq_q;
    logic [47:0] acc_q;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            freq_q <= '0;
            acc_q  <= '0;
        end else begin
            freq_q <= 48'(ctr_term + ofs_term + ser_term); // RL1
            acc_q  <= 48'(acc_q + freq_q); // RL3
        end
    end

    // One-period sine table
    typedef logic signed [15:0] rom_t [TBL_N];
    function automatic rom_t build_rom();
        rom_t r;
        real  v;
        for (int i = 0; i < TBL_N; i++) begin
            v = $sin(6.283185307179586 * i / TBL_N) * 32767.0;
            r[i] = 16'($rtoi(v < 0.0 ? v - 0.5 : v + 0.5));
        end
        return r;
    endfunction
    localparam rom_t SIN_ROM = build_rom(); // RL6

    logic [23:0] ph_addr;
    logic [15:0] samp_q;
    logic [13:0] round_q;
    logic [13:0] out_dly_q [nco_pkg::OUT_EXTRA];
    always_comb begin
        ph_addr = acc_q[47 -: nco_pkg::ADDR_W]; // RL4 RL6
        ph_addr[23:22] = 2'(ph_addr[23:22] + ph_s); // RL18 RL23
    end
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            samp_q  <= '0;
            round_q <= '0;
        end else begin
            samp_q <= SIN_ROM[ph_addr[23 -: TBL_BITS]]; // RL4
            if ($signed(samp_q) > 16'sh7ffd) begin
                round_q <= 14'h1fff; // RL5
            end else begin
                round_q <= 14'(($signed(samp_q) + 16'sh0002) >>> 2); // RL5
            end
        end
    end
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            out_dly_q <= '{default: '0};
        end else begin
            out_dly_q[0] <= round_q;
            for (int k = 1; k < nco_pkg::OUT_EXTRA; k++) begin
                out_dly_q[k] <= out_dly_q[k-1];
            end
        end
    end
    assign dac_sample = out_dly_q[nco_pkg::OUT_EXTRA-1];

    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    sequence s_wr(logic [3:0] a);
        wr_fire && a_s == a;
    endsequence
    sum_wrap_a: assert property (rst_n |=> freq_q == 48'($past(ctr_term) // RL1
        + $past(ofs_term) + $past(ser_term))) else $error("increment not the 48-bit sum");
    acc_step_a: assert property (rst_n |=> acc_q == 48'($past(acc_q) + $past(freq_q))) // RL3
        else $error("accumulator step wrong");
    round_out_a: assert property ($signed(samp_q) < 16'sh7ffe // RL5
        |=> ##4 dac_sample == 14'(($signed($past(samp_q, 5)) + 2) >>> 2))
        else $error("rounded sample wrong");
    phase_sel_a: assert property (ph_addr[23:22] == 2'(acc_q[47:46] + ph_s)) // RL23
        else $error("phase offset not applied");
    master_copy_a: assert property (wr_fire && copy_en && a_s < 4'(nco_pkg::NUM_MST) // RL9
        |=> slv_q[$past(a_s)] == $past(d_s)) else $error("held transfer missed write");
    reg15_xfer_a: assert property (s_wr(nco_pkg::ADDR_XFER) |-> ##3 copy_en) // RL19
        else $error("register 15 did not transfer");
    ofs_gate_a: assert property (!$past(ofs_s, 4) |-> ofs_term == 48'h0) // RL14
        else $error("offset term not gated");
    ser_hand_a: assert property (hold_load |=> req_q ##[1:2] ser_slv_q == hold_q) // RL25
        else $error("serial handshake stalled");
    ser_lat_a: assert property ($changed(ser_slv_q) |-> ##4 ser_dly_q[3] == $past(ser_slv_q, 4)) // RL17
        else $error("serial delay wrong");
    center_off_a: assert property (slv_q[nco_pkg::ADDR_CTRL][nco_pkg::CTRL_CTR_OFF] // RL2
        |-> ctr_term == 48'h0) else $error("center term not zeroed");
endmodule

// ### sim/host_model.sv
`timescale 1ns/10ps
// Host side of the block: parallel register writes and serial tuning frames
module host_model (
    input  wire logic       core_clk,
    output logic [7:0]      wr_data,
    output logic [3:0]      wr_addr,
    output logic            wr_enable_n,
    output logic            wr_strobe,
    output logic            ser_clk,
    output logic            ser_data,
    output logic            ser_sync
);
    int tick = 0;
    int rise_at;

    // Edge counter shared with the bench
    always @(posedge core_clk) tick <= tick + 1;

    // Idle levels at time zero
    initial begin
        {wr_data, wr_addr, wr_enable_n, wr_strobe} = 14'h0002;
        {ser_clk, ser_data, ser_sync} = 3'b000;
    end

    // One write: qualifiers set first, strobe high two clocks and low two
    task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic en_n);
        @(posedge core_clk);
        wr_addr     <= a;
        wr_data     <= d;
        wr_enable_n <= en_n;
        @(posedge core_clk);
        wr_strobe <= 1'b1;
        rise_at = tick + 2;
        repeat (2) @(posedge core_clk);
        wr_strobe <= 1'b0;
        repeat (2) @(posedge core_clk);
        wr_data     <= ~d;
        wr_addr     <= ~a;
        wr_enable_n <= 1'b1;
    endtask

    // One serial clock at 200 ns: data set while low
    task automatic sbit(input logic s, input logic d);
        ser_sync <= s;
        ser_data <= d;
        repeat (4) @(posedge core_clk);
        ser_clk <= 1'b1;
        repeat (4) @(posedge core_clk);
        ser_clk <= 1'b0;
    endtask

    // Sync, 8n bits MSB first, two tail clocks; clock stands still after
    task automatic send(input int n, input logic [39:0] w);
        @(posedge core_clk);
        sbit(1'b1, ~ser_data);
        for (int i = 0; i < 8 * n; i++) sbit(1'b0, w[39 - i]);
        sbit(1'b0, ~ser_data);
        sbit(1'b0, ~ser_data);
    endtask
endmodule

// ### sim/tb_top.sv
`timescale 1ns/10ps
module tb_top;
    typedef struct { int at; int lag; logic same; } rel_note_s;
    logic        core_clk           = 1'b0;
    logic        rst_n              = 1'b0;
    logic        update_n           = 1'b0;
    logic        phase_select_low   = 1'b0;
    logic        phase_select_high  = 1'b0;
    logic        offset_word_enable = 1'b0;
    logic [7:0]  wr_data;
    logic [3:0]  wr_addr;
    logic        wr_enable_n;
    logic        wr_strobe;
    logic        ser_clk;
    logic        ser_data;
    logic        ser_sync;
    logic [13:0] dac_sample;
    logic [13:0] hist [16];
    rel_note_s   notes [$];
    int          n_errors = 0;
    int          n_tests  = 0;
    int          ev_at;

    // 40 MHz clock
    always #12.5 core_clk = ~core_clk;

    nco_frequency_control nco_frequency_control_inst (
        .core_clk(core_clk), .rst_n(rst_n), .wr_data(wr_data), .wr_addr(wr_addr),
        .wr_enable_n(wr_enable_n), .wr_strobe(wr_strobe), .update_n(update_n),
        .phase_select_low(phase_select_low), .phase_select_high(phase_select_high),
        .offset_word_enable(offset_word_enable), .ser_clk(ser_clk), .ser_data(ser_data),
        .ser_sync(ser_sync), .dac_sample(dac_sample)
    );
    host_model host_model_inst (
        .core_clk(core_clk), .wr_data(wr_data), .wr_addr(wr_addr),
        .wr_enable_n(wr_enable_n), .wr_strobe(wr_strobe), .ser_clk(ser_clk),
        .ser_data(ser_data), .ser_sync(ser_sync)
    );

    task automatic check_rel(input logic [13:0] got, input logic [13:0] ref_v, input logic same);
        n_tests++;
        if ((got === ref_v) !== same) begin
            n_errors++;
            $display("unexpected at %0t: sample %h against %h", $time, got, ref_v);
        end
    endtask

    // Record each settled sample and settle the notes due now
    always @(negedge core_clk) begin
        hist[host_model_inst.tick % 16] = dac_sample;
        while (notes.size() > 0 && notes[0].at == host_model_inst.tick) begin
            check_rel(dac_sample, hist[(notes[0].at - notes[0].lag) % 16], notes[0].same);
            void'(notes.pop_front());
        end
    end

    task automatic expect_run(input int at, input int lag, input logic same, input int cnt);
        for (int i = 0; i < cnt; i++) notes.push_back('{at + i, lag, same});
    endtask

    task automatic drain();
        for (int i = 0; i < 600 && notes.size() > 0; i++) @(posedge core_clk);
        if (notes.size() > 0) begin
            n_errors++;
            $display("unexpected at %0t: notes left unsettled", $time);
            notes.delete();
        end
    endtask

    task automatic pins(input logic upd, input logic [1:0] ph, input logic ofs);
        @(posedge core_clk);
        update_n <= upd;
        {phase_select_high, phase_select_low} <= ph;
        offset_word_enable <= ofs;
        ev_at = host_model_inst.tick + 2;
        repeat (4) @(posedge core_clk); // Transfer pipeline settles before any write
    endtask

    task automatic word(input logic [3:0] base, input logic [47:0] v);
        for (int i = 0; i < 6; i++) host_model_inst.wr(4'(base + i), v[8 * i +: 8], 1'b0);
    endtask

    task automatic final_report();
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // Main sequence
    initial begin
        void'($urandom(32'h86aee8d2));
        repeat (5) @(posedge core_clk);
        rst_n <= 1'b1;
        expect_run(host_model_inst.tick + 20, 4, 1'b1, 8);
        expect_run(host_model_inst.tick + 32, 1, 1'b0, 8);
        drain();
        host_model_inst.wr(nco_pkg::ADDR_CTRL, 8'h80, 1'b0);
        ev_at = host_model_inst.rise_at;
        expect_run(ev_at + 9, 1, 1'b0, 1);
        expect_run(ev_at + 10, 1, 1'b1, 6);
        drain();
        // Masters fill while the transfer pin is high
        pins(1'b1, 2'b00, 1'b0);
        word(nco_pkg::CENTER_BASE, 48'h2000_0000_0000);
        host_model_inst.wr(nco_pkg::ADDR_CTRL, 8'h00, 1'b0);
        expect_run(host_model_inst.tick + 2, 1, 1'b1, 8);
        drain();
        pins(1'b0, 2'b00, 1'b0);
        expect_run(ev_at + 12, 1, 1'b1, 1);
        expect_run(ev_at + 13, 1, 1'b0, 1);
        expect_run(ev_at + 20, 8, 1'b1, 16);
        drain();
        // Each quarter turn shifts the eighth-rate sine by two samples
        for (int k = 1; k <= 4; k++) begin
            pins(1'b0, 2'(k % 4), 1'b0);
            expect_run(ev_at + 7, 6, 1'b1, 6);
            drain();
        end
        word(nco_pkg::OFFSET_BASE, 48'h2000_0000_0000);
        host_model_inst.wr(4'he, 8'($urandom), 1'b0);
        host_model_inst.wr(4'(nco_pkg::CENTER_BASE + 5), {3'($urandom), 5'h10}, 1'b1);
        expect_run(host_model_inst.tick + 2, 8, 1'b1, 16);
        drain();
        pins(1'b0, 2'b00, 1'b1);
        expect_run(ev_at + 12, 8, 1'b1, 1);
        expect_run(ev_at + 13, 8, 1'b0, 1);
        expect_run(ev_at + 22, 4, 1'b1, 8);
        drain();
        pins(1'b1, 2'b00, 1'b1);
        host_model_inst.wr(4'hb, 8'h00, 1'b0);
        host_model_inst.wr(nco_pkg::ADDR_XFER, 8'($urandom), 1'b0);
        ev_at = host_model_inst.rise_at;
        expect_run(ev_at + 12, 4, 1'b1, 1);
        expect_run(ev_at + 13, 4, 1'b0, 1);
        drain();
        // Serial word alone drives the rate
        pins(1'b0, 2'b00, 1'b0);
        host_model_inst.wr(nco_pkg::ADDR_CTRL, 8'h80, 1'b0);
        host_model_inst.wr(nco_pkg::ADDR_SCFG, 8'h02, 1'b0);
        host_model_inst.send(2, 40'h20_0000_0000);
        expect_run(host_model_inst.tick + 30, 8, 1'b1, 16);
        expect_run(host_model_inst.tick + 46, 1, 1'b0, 4);
        drain();
        host_model_inst.wr(nco_pkg::ADDR_SCFG, 8'h05, 1'b0);
        host_model_inst.send(5, {8'h00, 32'($urandom)});
        host_model_inst.wr(nco_pkg::ADDR_SCFG, 8'h01, 1'b0);
        host_model_inst.send(1, 40'h40_0000_0000);
        expect_run(host_model_inst.tick + 30, 4, 1'b1, 8);
        drain();
        final_report();
    end

    // Watchdog well beyond the expected run length
    initial begin
        #400_000;
        n_errors++;
        $display("unexpected at %0t: run did not finish", $time);
        final_report();
    end
endmodule
